// file: bench/host_cpu_bus_port_bench.sv
// Purpose: Random and corner accesses in both bus styles.
// Assumes: Inputs change on the falling edge.
// Notes: Shadow arrays predict read data.
module host_cpu_bus_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, bus_style, internal_tie_high, cs_n, irq_pending;
  logic write_or_direction, read_strobe_or_data_strobe, data_oe;
  logic external_memory_target, irq_out, irq_oe, int_valid, int_ready;
  logic ready_or_acknowledge, ready_or_acknowledge_oe, ext_valid, ext_ready;
  logic [15:1] addr_in;
  logic [15:0] data_in, data_out, int_rdata, ext_rdata;
  logic [15:0] im [16], em [16];
  logic [1:0] lat;
  host_port_pkg::mem_req_t tgt_req;
  int fails, tests_run;
  host_cpu_bus_port DUT (.*);
  target_model #(.BASE(16'h1000)) int_mem (.clk(clk), .valid(int_valid),
    .req(tgt_req), .lat(lat), .ready(int_ready), .rdata(int_rdata));
  target_model #(.BASE(16'h2000)) ext_mem (.clk(clk), .valid(ext_valid),
    .req(tgt_req), .lat(lat), .ready(ext_ready), .rdata(ext_rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] exp_rd(input logic ext, input int i);
    return ext ? em[i] : im[i];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic idle;
    cs_n = 1'b1;
    internal_tie_high = 1'b1;
    write_or_direction = 1'b1;
    read_strobe_or_data_strobe = 1'b1;
    @(negedge clk);
  endtask
  task automatic xfer(input logic wr, ext, input logic [15:1] a,
                      input logic [15:0] d);
    int n;
    @(negedge clk);
    lat = 2'($urandom_range(3));
    cs_n = 1'b0;
    external_memory_target = ext;
    addr_in = a;
    data_in = d;
    write_or_direction = !wr;
    read_strobe_or_data_strobe = bus_style & wr;
    n = 0;
    while ((bus_style ? ready_or_acknowledge : ready_or_acknowledge_oe)
           !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      fails++;
      final_report();
    end
    check(data_oe, !wr);
    if (!wr) check(data_out, exp_rd(ext, a[4:1]));
    else if (ext) em[a[4:1]] = d;
    else im[a[4:1]] = d;
    data_in = ~d;
    idle();
    check(ready_or_acknowledge_oe, 1'b0);
  endtask
  task automatic refuse(input logic c, input logic t);
    @(negedge clk);
    cs_n = c;
    internal_tie_high = t;
    write_or_direction = 1'b0;
    read_strobe_or_data_strobe = 1'b0;
    repeat (4) @(negedge clk) check(int_valid | ext_valid, 1'b0);
    idle();
  endtask
  initial begin
    {rst_n, irq_pending, external_memory_target, lat} = 5'h00;
    bus_style = 1'b1;
    {addr_in, data_in, fails, tests_run} = 95'h0;
    idle();
    for (int i = 0; i < 16; i++) begin
      im[i] = 16'h1000 ^ 16'(i);
      em[i] = 16'h2000 ^ 16'(i);
    end
    void'($urandom(32'hE529));
    for (int s = 1; s >= 0; s--) begin
      rst_n = 1'b0;
      bus_style = s[0];
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      refuse(1'b1, 1'b1);
      refuse(1'b0, 1'b0);
      if (s == 1) refuse(1'b0, 1'b1);
      xfer(1'b1, 1'b1, 15'h7FFF, 16'hFFFF);
      xfer(1'b0, 1'b1, 15'h7FFF, 16'h0000);
      repeat (30) xfer(1'($urandom), 1'($urandom), 15'($urandom),
                       16'($urandom));
      irq_pending = 1'b1;
      @(negedge clk);
      check({irq_oe, irq_out}, 2'h2);
      irq_pending = 1'b0;
      @(negedge clk);
      check(irq_oe, 1'b0);
    end
    final_report();
  end
endmodule // host_cpu_bus_port_bench

// file: bench/host_port_assertions.sv
// Purpose: Pin timing checks of the host port.
// Assumes: Strap changes only under reset.
// Notes: Bound to host_cpu_bus_port.
module host_port_assertions (
  input wire logic clk, // pin
  input wire logic rst_n, // pin
  input wire logic bus_style, // pin
  input wire logic cs_n, // pin
  input wire logic external_memory_target, // pin
  input wire logic [15:1] addr_in, // pin
  input wire logic data_oe, // pin
  input wire logic ready_or_acknowledge, // pin
  input wire logic ready_or_acknowledge_oe, // pin
  input wire logic irq_out, // pin
  input wire logic irq_oe, // pin
  input wire logic irq_pending, // pin
  input wire host_port_pkg::mem_req_t tgt_req, // pin
  input wire logic int_valid, // pin
  input wire logic int_ready, // pin
  input wire logic ext_valid, // pin
  input wire logic ext_ready // pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ack;
  logic any_v;
  logic take;
  assign ack = bus_style ? ready_or_acknowledge : ready_or_acknowledge_oe;
  assign any_v = int_valid | ext_valid;
  assign take = int_valid & int_ready | ext_valid & ext_ready;
  no_select_a: assert property (cs_n && !any_v |=> !any_v)
    else $error("access began unselected");
  pin_release_a: assert property (cs_n |=>
    !data_oe && !ready_or_acknowledge_oe) else $error("pins kept");
  ack_level_a: assert property (!bus_style |-> !ready_or_acknowledge)
    else $error("acknowledge driven high");
  irq_follow_a: assert property ($past(rst_n) |->
    irq_oe == $past(irq_pending) && !irq_out) else $error("irq wrong");
  route_a: assert property ($rose(any_v) |->
    ext_valid == $past(external_memory_target) && int_valid != ext_valid)
    else $error("wrong target");
  word_addr_a: assert property ($rose(any_v) |->
    tgt_req.addr == {$past(addr_in), 1'b0}) else $error("bad address");
  early_ack_a: assert property (any_v |=> !ack)
    else $error("answer before access done");
  ack_bound_a: assert property (take |-> ##2 ack)
    else $error("answer late");
  cover property (bus_style && $rose(ack));
  cover property (!bus_style && $rose(ack));
  cover property ($rose(ext_valid));
endmodule // host_port_assertions

bind host_cpu_bus_port host_port_assertions chk (.*);

// file: bench/target_model.sv
// Purpose: Memory target answering valid/ready requests.
// Assumes: Index from address bits 4 to 1.
// Notes: Read data toggles while not answering.
module target_model #(parameter logic [15:0] BASE = 16'h0000) (
  input wire logic clk, // Clock
  input wire logic valid, // Request valid
  input wire host_port_pkg::mem_req_t req, // Request
  input wire logic [1:0] lat, // Wait cycles
  output logic ready, // Accept
  output logic [15:0] rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  logic [1:0] cnt;
  initial begin
    ready = 1'b0;
    rdata = 16'h0000;
    cnt = 2'h0;
    for (int i = 0; i < 16; i++) mem[i] = BASE ^ 16'(i);
  end
  always @(posedge clk) begin
    if (valid && !ready && cnt == lat) begin
      ready <= 1'b1;
      rdata <= mem[req.addr[4:1]];
      if (req.write) mem[req.addr[4:1]] <= req.wdata;
      cnt <= 2'h0;
    end else begin
      ready <= 1'b0;
      rdata <= ~rdata;
      if (valid && !ready) cnt <= cnt + 2'h1;
    end
  end
endmodule // target_model

// file: hdl/access_router.sv
// Purpose: Routes one host access to internal or external memory.
// Assumes: Targets use valid/ready; read data valid with ready.
// Notes: done pulses one cycle after the target accepts.
`include "host_port_defs.svh"

module access_router (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic start, // One-cycle access request
  input wire logic ext, // Access targets external memory
  input wire host_port_pkg::mem_req_t req, // Access to perform
  output host_port_pkg::mem_req_t tgt_req, // Request to both targets
  output logic int_valid, // Request valid, internal target
  input wire logic int_ready, // Internal target accepts
  input wire logic [15:0] int_rdata, // Internal read data
  output logic ext_valid, // Request valid, external memory
  input wire logic ext_ready, // External memory accepts
  input wire logic [15:0] ext_rdata, // External read data
  output logic done, // One-cycle completion pulse
  output logic [15:0] rdata // Captured read data
);

  host_port_pkg::router_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && start) begin
      s_d.busy = 1'b1;
      s_d.req = req;
      s_d.int_valid = (ext != `TARGET_EXTERNAL);
      s_d.ext_valid = (ext == `TARGET_EXTERNAL);
    end else if (s_q.int_valid && int_ready) begin
      s_d.busy = 1'b0;
      s_d.int_valid = 1'b0;
      s_d.done = 1'b1;
      if (!s_q.req.write) begin
        s_d.rdata = int_rdata;
      end
    end else if (s_q.ext_valid && ext_ready) begin
      s_d.busy = 1'b0;
      s_d.ext_valid = 1'b0;
      s_d.done = 1'b1;
      if (!s_q.req.write) begin
        s_d.rdata = ext_rdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tgt_req = s_q.req;
  assign int_valid = s_q.int_valid;
  assign ext_valid = s_q.ext_valid;
  assign done = s_q.done;
  assign rdata = s_q.rdata;

endmodule // access_router

// file: hdl/host_cpu_bus_port.sv
// Purpose: Sixteen-bit asynchronous-strobe host processor port.
// Assumes: Pins already synchronous to clk; targets use valid/ready.
// Notes: Pin outputs come from flops, so they lag the pins by one cycle.
// Notes on behaviour
// - Strobes count only while cs_n is low and are ignored while it is high.
// - The write pin is a low write strobe, or the read/write direction line.
// - The read pin is a low read strobe, or the low data strobe.
// - In data-strobe style acknowledge is pulled low while selected once the access is done, else released.
// - Separate style: ready is driven while selected, else released.
// - The interrupt pin is pulled low while one is pending, else released.
// - external_memory_target high routes to external memory, low to internal.
// - Every access moves a whole 16-bit word; no byte transfers exist.
// - Address bits 15 to 1 are driven; the absent bit 0 is the byte select.
`include "host_port_defs.svh"

module host_cpu_bus_port (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic bus_style, // Strap: 1 separate strobes, 0 data strobe
  input wire logic internal_tie_high, // Must be held high
  input wire logic cs_n, // Chip select, active low
  input wire logic write_or_direction, // Write strobe or read/write line
  input wire logic read_strobe_or_data_strobe, // Read or data strobe
  input wire logic external_memory_target, // 1 external memory, 0 internal
  input wire logic [15:1] addr_in, // Word address bits
  input wire logic [15:0] data_in, // Data bus input
  output logic [15:0] data_out, // Data bus output
  output logic data_oe, // Data bus drive enable
  output logic ready_or_acknowledge, // Ready or acknowledge level
  output logic ready_or_acknowledge_oe, // Ready or acknowledge enable
  output logic irq_out, // Interrupt pin level, always low
  output logic irq_oe, // Interrupt pin pulled while high
  input wire logic irq_pending, // Internal interrupt pending
  output host_port_pkg::mem_req_t tgt_req, // Request to targets
  output logic int_valid, // Request valid, internal target
  input wire logic int_ready, // Internal target accepts
  input wire logic [15:0] int_rdata, // Internal read data
  output logic ext_valid, // Request valid, external memory
  input wire logic ext_ready, // External memory accepts
  input wire logic [15:0] ext_rdata // External read data
);

  host_port_pkg::port_state_t s_q, s_d;
  logic sel;
  logic sep;
  logic wr_act;
  logic rd_act;
  logic done;
  logic [15:0] rdata;

  access_router u_router (
    .clk(clk),
    .rst_n(rst_n),
    .start(s_q.start),
    .ext(s_q.ext),
    .req(s_q.req),
    .tgt_req(tgt_req),
    .int_valid(int_valid),
    .int_ready(int_ready),
    .int_rdata(int_rdata),
    .ext_valid(ext_valid),
    .ext_ready(ext_ready),
    .ext_rdata(ext_rdata),
    .done(done),
    .rdata(rdata)
  );

  always_comb begin
    sel = !cs_n && internal_tie_high;
    sep = (bus_style == `STYLE_SEPARATE);
    if (sep) begin
      wr_act = !write_or_direction;
      rd_act = !read_strobe_or_data_strobe;
    end else begin
      wr_act = !read_strobe_or_data_strobe &&
               (write_or_direction != `DIR_READ);
      rd_act = !read_strobe_or_data_strobe &&
               (write_or_direction == `DIR_READ);
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    unique case (s_q.fsm)
      host_port_pkg::ST_IDLE: begin
        // Both separate strobes low at once is ambiguous and ignored
        if (sel && (wr_act ^ rd_act)) begin
          s_d.fsm = host_port_pkg::ST_BUSY;
          s_d.start = 1'b1;
          s_d.ext = external_memory_target;
          s_d.req.write = wr_act;
          s_d.req.addr = {addr_in, 1'b0};
          s_d.req.addr[`BYTE_SEL_BIT] = 1'b0;
          s_d.req.wdata = wr_act ? data_in : `RST_WORD;
        end
      end
      host_port_pkg::ST_BUSY: begin
        if (done) begin
          s_d.fsm = host_port_pkg::ST_DONE;
          if (!s_q.req.write) begin
            s_d.data_out = rdata;
          end
        end
      end
      host_port_pkg::ST_DONE: begin
        if (!sel || !(wr_act || rd_act)) begin
          s_d.fsm = host_port_pkg::ST_IDLE;
        end
      end
    endcase
    s_d.data_oe = sel && rd_act && !s_q.req.write &&
                  (s_d.fsm == host_port_pkg::ST_DONE);
    if (sep) begin
      s_d.rdy_oe = sel;
      s_d.rdy_out = (s_d.fsm == host_port_pkg::ST_DONE);
    end else begin
      s_d.rdy_out = 1'b0;
      s_d.rdy_oe = sel &&
                   (s_d.fsm == host_port_pkg::ST_DONE);
    end
    s_d.irq_out = 1'b0;
    s_d.irq_oe = irq_pending;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.data_out;
  assign data_oe = s_q.data_oe;
  assign ready_or_acknowledge = s_q.rdy_out;
  assign ready_or_acknowledge_oe = s_q.rdy_oe;
  assign irq_out = s_q.irq_out;
  assign irq_oe = s_q.irq_oe;

endmodule // host_cpu_bus_port

// file: hdl/host_port_defs.svh
// Purpose: Constants of the host processor bus port.
// Assumes: Included by bare name from design files.
// Notes: Definitions only.
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// Strap level choosing separate read and write strobes
`define STYLE_SEPARATE 1'b1
// Strap level choosing data strobe with direction line
`define STYLE_DATA_STROBE 1'b0
// Level of external_memory_target that selects external memory
`define TARGET_EXTERNAL 1'b1
// Direction line level meaning read in data-strobe style
`define DIR_READ 1'b1
// Position of the byte-select bit inside a byte address
`define BYTE_SEL_BIT 0
// Reset values
`define RST_WORD 16'h0000
`define RST_BIT 1'b0

`endif

// file: hdl/host_port_pkg.sv
// Purpose: Types shared by the host port and its access router.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in host_port_defs.svh.
package host_port_pkg;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_DONE
  } port_fsm_t;

  typedef struct packed {
    port_fsm_t fsm;
    logic start;
    logic ext;
    mem_req_t req;
    logic [15:0] data_out;
    logic data_oe;
    logic rdy_out;
    logic rdy_oe;
    logic irq_out;
    logic irq_oe;
  } port_state_t;

  typedef struct packed {
    logic busy;
    logic int_valid;
    logic ext_valid;
    mem_req_t req;
    logic done;
    logic [15:0] rdata;
  } router_state_t;

endpackage
